// [irt_pkg.sv]
package irt_pkg;
    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [7:0] SYMBOL_BYTE_COUNT_ADDR = 8'hA7;
    localparam logic [7:0] TRANSMIT_STATUS_ADDR = 8'hA8;
    localparam logic [7:0] TRANSMIT_LAUNCH_ADDR = 8'hA9;
    localparam logic [7:0] SYMBOL_BYTE_COUNT_RST = 8'h01;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int LAUNCH_BARCODE_BIT = 0;
    localparam int LAUNCH_REMOTE_BIT = 1;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int QUARTER_US_NS = 250;
    // Rounds down: 31 cycles, so a quarter step runs 248 ns, not 250 ns
    localparam int QUARTER_CYC = QUARTER_US_NS / CLK_PERIOD_NS;
    localparam int BYTE_BITS = 8;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        IRT_IDLE,
        IRT_LOAD,
        IRT_BITS,
        IRT_GAP_SYM,
        IRT_GAP_PKT
    } irt_state_t;

    // Loose configuration bits held outside this block
    typedef struct packed {
        logic [5:0] bit_time_setting;
        logic [7:0] symbol_repeat_count;
        logic [7:0] packet_repeat_count;
        logic [7:0] inter_symbol_gap;
        logic [7:0] inter_packet_gap;
        logic transmit_done_irq_enable;
    } irt_cfg_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irt_reg_req_t;
endpackage : irt_pkg

// [irt_fifo.sv]
`timescale 1ns/1ns
module irt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule : irt_fifo

// [irt_tx_ctrl.sv]
`timescale 1ns/1ns
// Functional notes
// - A symbol carries symbol_byte_count plus one pattern bytes.
// - With irq enable set, finishing a block sets the done flag, status bit 1.
// - The done flag is mirrored to the main status output.
// - Status bit 0 is high exactly while a transmission runs.
// - Launch bit 1 starts remote control from address 0; writing 0 stops.
// - Launch bit 0 starts barcode emulation; writing 0 stops.
// - Bit time is bit_time_setting plus one quarter steps of 248 ns.
// - Each packet repeats the symbol symbol_repeat_count plus one times.
// - The packet is sent packet_repeat_count plus one times.
// - Gaps last twice the gap setting plus one bit times; setting at least 8.
module irt_tx_ctrl #(
    parameter int DEPTH = irt_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire irt_pkg::irt_reg_req_t reg_req,
    output logic [7:0] reg_rdata_ff,
    input wire irt_pkg::irt_cfg_t cfg,
    input wire logic pat_valid,
    input wire logic [7:0] pat_data,
    output logic pat_ready,
    output logic [7:0] pattern_addr_ff,
    output logic emitter_on_ff,
    output logic transmit_in_progress_ff,
    output logic transmit_done_flag_ff,
    output logic main_status_done_ff
);
    // ***************************************************************
    // Declarations
    // ***************************************************************
    irt_pkg::irt_state_t state_ff;
    logic [7:0] symbol_byte_count_ff;
    logic [1:0] launch_ff;
    logic [4:0] quarter_cnt_ff;
    logic [5:0] bit_cnt_ff;
    logic [2:0] bit_idx_ff;
    logic [7:0] byte_cnt_ff;
    logic [7:0] sym_cnt_ff;
    logic [7:0] pkt_cnt_ff;
    logic [8:0] gap_cnt_ff;
    logic [7:0] shift_ff;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_in_ready;
    logic [7:0] fifo_data;
    logic quarter_tick;
    logic bit_tick;
    logic wr_launch;
    logic start_req;
    logic stop_req;
    logic finish;
    logic rd_status;
    logic pat_ready_ff;

    assign pat_ready = pat_ready_ff;
    assign wr_launch = reg_req.wr_en && (reg_req.addr == irt_pkg::TRANSMIT_LAUNCH_ADDR);
    assign rd_status = reg_req.rd_en && (reg_req.addr == irt_pkg::TRANSMIT_STATUS_ADDR);
    assign start_req = wr_launch && (state_ff == irt_pkg::IRT_IDLE) && (reg_req.wdata[1:0] != 2'h0);
    // Stop when the running mode bit is written as zero
    assign stop_req = wr_launch && (state_ff != irt_pkg::IRT_IDLE)
        && ((reg_req.wdata[1:0] & launch_ff) == 2'h0);
    assign fifo_ready = (state_ff == irt_pkg::IRT_LOAD);

    // Pattern buffer; the engine stalls in LOAD while it is empty
    irt_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(pat_valid && pat_ready_ff), // Only a byte offered while ready counts
        .in_data(pat_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_ready)
    );

    // Registered buffer ready, dropped for a cycle after each accepted byte; keeps the port flop-driven
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pat_ready_ff <= 1'b0;
        end else begin
            pat_ready_ff <= fifo_in_ready && !(pat_valid && pat_ready_ff);
        end
    end

    // ***************************************************************
    // Bit timing
    // ***************************************************************
    assign quarter_tick = (quarter_cnt_ff == 5'(irt_pkg::QUARTER_CYC - 1));
    assign bit_tick = quarter_tick && (bit_cnt_ff == cfg.bit_time_setting);

    // Dividers restart on launch so the first bit falls one cycle short of full length
    always_ff @(posedge mclk) begin
        if (!rst_n || start_req) begin
            quarter_cnt_ff <= '0;
            bit_cnt_ff <= '0;
        end else begin
            quarter_cnt_ff <= quarter_tick ? '0 : quarter_cnt_ff + 1'b1;
            if (quarter_tick) begin
                bit_cnt_ff <= bit_tick ? '0 : bit_cnt_ff + 1'b1;
            end
        end
    end

    // ***************************************************************
    // Registers
    // ***************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            symbol_byte_count_ff <= irt_pkg::SYMBOL_BYTE_COUNT_RST;
        end else if (reg_req.wr_en && (reg_req.addr == irt_pkg::SYMBOL_BYTE_COUNT_ADDR)) begin
            symbol_byte_count_ff <= reg_req.wdata;
        end
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_req.rd_en) begin
            if (reg_req.addr == irt_pkg::SYMBOL_BYTE_COUNT_ADDR) begin
                reg_rdata_ff <= symbol_byte_count_ff;
            end else if (reg_req.addr == irt_pkg::TRANSMIT_STATUS_ADDR) begin
                reg_rdata_ff <= {6'h00, transmit_done_flag_ff, transmit_in_progress_ff};
            end else if (reg_req.addr == irt_pkg::TRANSMIT_LAUNCH_ADDR) begin
                reg_rdata_ff <= {6'h00, launch_ff};
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    // ***************************************************************
    // Sequencer
    // ***************************************************************
    assign finish = bit_tick && (state_ff == irt_pkg::IRT_BITS)
        && (bit_idx_ff == 3'(irt_pkg::BYTE_BITS - 1)) && (byte_cnt_ff == symbol_byte_count_ff)
        && (sym_cnt_ff == cfg.symbol_repeat_count) && (pkt_cnt_ff == cfg.packet_repeat_count);

    // Main state and loop counters
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= irt_pkg::IRT_IDLE;
            launch_ff <= 2'h0;
            bit_idx_ff <= '0;
            byte_cnt_ff <= '0;
            sym_cnt_ff <= '0;
            pkt_cnt_ff <= '0;
            gap_cnt_ff <= '0;
            shift_ff <= '0;
            pattern_addr_ff <= '0;
        end else if (start_req) begin
            state_ff <= irt_pkg::IRT_LOAD;
            launch_ff <= reg_req.wdata[1:0];
            byte_cnt_ff <= '0;
            sym_cnt_ff <= '0;
            pkt_cnt_ff <= '0;
            pattern_addr_ff <= '0;
        end else if (stop_req || finish) begin
            state_ff <= irt_pkg::IRT_IDLE;
            launch_ff <= 2'h0;
        end else begin
            case (state_ff)
                irt_pkg::IRT_LOAD: begin
                    if (fifo_valid) begin
                        shift_ff <= fifo_data;
                        bit_idx_ff <= '0;
                        pattern_addr_ff <= pattern_addr_ff + 1'b1;
                        state_ff <= irt_pkg::IRT_BITS;
                    end
                end
                irt_pkg::IRT_BITS: begin
                    if (bit_tick) begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        bit_idx_ff <= bit_idx_ff + 1'b1;
                        if (bit_idx_ff == 3'(irt_pkg::BYTE_BITS - 1)) begin
                            if (byte_cnt_ff != symbol_byte_count_ff) begin
                                byte_cnt_ff <= byte_cnt_ff + 1'b1;
                                state_ff <= irt_pkg::IRT_LOAD;
                            end else if (sym_cnt_ff != cfg.symbol_repeat_count) begin
                                byte_cnt_ff <= '0;
                                sym_cnt_ff <= sym_cnt_ff + 1'b1;
                                gap_cnt_ff <= {cfg.inter_symbol_gap, 1'b0};
                                state_ff <= irt_pkg::IRT_GAP_SYM;
                            end else begin
                                byte_cnt_ff <= '0;
                                sym_cnt_ff <= '0;
                                pkt_cnt_ff <= pkt_cnt_ff + 1'b1;
                                gap_cnt_ff <= {cfg.inter_packet_gap, 1'b0};
                                state_ff <= irt_pkg::IRT_GAP_PKT;
                            end
                        end
                    end
                end
                irt_pkg::IRT_GAP_SYM, irt_pkg::IRT_GAP_PKT: begin
                    // Gap of 2*setting+1 bit times, counted down to zero
                    if (bit_tick) begin
                        if (gap_cnt_ff == '0) begin
                            state_ff <= irt_pkg::IRT_LOAD;
                        end else begin
                            gap_cnt_ff <= gap_cnt_ff - 1'b1;
                        end
                    end
                end
                default: begin
                    state_ff <= irt_pkg::IRT_IDLE;
                end
            endcase
        end
    end

    // ***************************************************************
    // Outputs and flags
    // ***************************************************************
    // emitter off outside bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            emitter_on_ff <= 1'b0;
        end else begin
            emitter_on_ff <= (state_ff == irt_pkg::IRT_BITS) && shift_ff[7] && !stop_req && !finish;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            transmit_in_progress_ff <= 1'b0;
        end else begin
            transmit_in_progress_ff <= start_req
                || ((state_ff != irt_pkg::IRT_IDLE) && !stop_req && !finish);
        end
    end

    // done flag, read of status clears, a new event wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            transmit_done_flag_ff <= 1'b0;
            main_status_done_ff <= 1'b0;
        end else if (finish && cfg.transmit_done_irq_enable) begin
            transmit_done_flag_ff <= 1'b1;
            main_status_done_ff <= 1'b1;
        end else if (rd_status) begin
            transmit_done_flag_ff <= 1'b0;
            main_status_done_ff <= 1'b0;
        end
    end
endmodule : irt_tx_ctrl

// [irt_tx_checker.sv]
`timescale 1ns/1ns
module irt_tx_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire irt_pkg::irt_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_ff,
    input wire irt_pkg::irt_cfg_t cfg,
    input wire logic pat_valid,
    input wire logic [7:0] pat_data,
    input wire logic pat_ready,
    input wire logic [7:0] pattern_addr_ff,
    input wire logic emitter_on_ff,
    input wire logic transmit_in_progress_ff,
    input wire logic transmit_done_flag_ff,
    input wire logic main_status_done_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Launch decode; a zero mode field means stop, so go and stop share it
    wire logic lch = reg_req.wr_en && reg_req.addr == irt_pkg::TRANSMIT_LAUNCH_ADDR;
    wire logic go = lch && reg_req.wdata[1:0] != 2'b00;
    wire logic busy = transmit_in_progress_ff;
    property p_mirror; main_status_done_ff == transmit_done_flag_ff; endproperty
    a_mirror: assert property (p_mirror) else $error("done mirror differs");
    property p_launch; go && !busy |=> busy && pattern_addr_ff == 8'h00; endproperty
    a_launch: assert property (p_launch) else $error("launch did not start at 0");
    property p_stop; lch && !go && busy |=> !busy ##1 !emitter_on_ff; endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt");
    property p_dark; !busy && !$past(busy) |-> !emitter_on_ff; endproperty
    a_dark: assert property (p_dark) else $error("emitter lit while idle");
    property p_done_src;
        $rose(transmit_done_flag_ff) |-> $fell(busy) && cfg.transmit_done_irq_enable;
    endproperty
    a_done_src: assert property (p_done_src) else $error("done set off finish");
    property p_finish;
        $fell(busy) && !$past(lch) && cfg.transmit_done_irq_enable |-> transmit_done_flag_ff;
    endproperty
    a_finish: assert property (p_finish) else $error("done missing at finish");
    property p_status;
        reg_req.rd_en && reg_req.addr == irt_pkg::TRANSMIT_STATUS_ADDR |=>
            reg_rdata_ff == {6'h00, $past(transmit_done_flag_ff), $past(busy)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_ready_gap; pat_valid && pat_ready |=> !pat_ready; endproperty
    a_ready_gap: assert property (p_ready_gap) else $error("ready not dropped");
    property p_emit; emitter_on_ff |-> busy || $past(busy); endproperty
    a_emit: assert property (p_emit) else $error("emitter on without busy");
    property p_addr_step;
        busy && $past(busy) && $changed(pattern_addr_ff) |->
            pattern_addr_ff == $past(pattern_addr_ff) + 8'h01;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("pattern address skipped");
endmodule : irt_tx_checker
bind irt_tx_ctrl irt_tx_checker irt_tx_checker_inst (.mclk(mclk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff), .cfg(cfg), .pat_valid(pat_valid),
    .pat_data(pat_data), .pat_ready(pat_ready), .pattern_addr_ff(pattern_addr_ff),
    .emitter_on_ff(emitter_on_ff), .transmit_in_progress_ff(transmit_in_progress_ff),
    .transmit_done_flag_ff(transmit_done_flag_ff), .main_status_done_ff(main_status_done_ff));

// [irt_ir_receiver.sv]
`timescale 1ns/1ns
module irt_ir_receiver (
    input wire logic mclk,
    input wire logic clr,
    input wire logic listen,
    input wire logic emitter_on_ff,
    output int on_cycles,
    output int max_off,
    output int frame_cycles
);
    int off_run;
    // Integrate light and track the longest dark span within one frame
    always @(posedge mclk) begin
        if (clr) begin
            on_cycles <= 0;
            max_off <= 0;
            off_run <= 0;
        end else if (emitter_on_ff) begin
            on_cycles <= on_cycles + 1;
            off_run <= 0;
        end else if (listen) begin
            off_run <= off_run + 1;
            if (off_run + 1 > max_off) begin
                max_off <= off_run + 1;
            end
        end
    end

    // Frame length while busy; exposes every gap and repeat in one number
    always @(posedge mclk) begin
        if (clr) begin
            frame_cycles <= 0;
        end else if (listen) begin
            frame_cycles <= frame_cycles + 1;
        end
    end
endmodule : irt_ir_receiver

// [test_irt_tx_ctrl.sv]
`timescale 1ns/1ns
module test_irt_tx_ctrl;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    irt_pkg::irt_reg_req_t reg_req = '0;
    irt_pkg::irt_cfg_t cfg = '0;
    logic pat_valid = 1'b0;
    logic [7:0] pat_data = 8'h00;
    logic clr = 1'b0;
    logic [7:0] reg_rdata_ff;
    logic [7:0] pattern_addr_ff;
    logic pat_ready, emitter_on_ff, transmit_in_progress_ff, transmit_done_flag_ff;
    logic main_status_done_ff;
    int on_cycles, max_off, frame_cycles, bit_cyc, ones;
    int mismatches = 0;
    int cmp_count = 0;
    // Register rows: address, write data, expected readback
    logic [7:0] rows [4][3] = '{'{8'hA7, 8'h03, 8'h03}, '{8'hA7, 8'h01, 8'h01},
        '{8'hA8, 8'hFF, 8'h00}, '{8'h00, 8'h5A, 8'h00}};
    // Every byte starts and ends dark so a stalled first bit cannot skew the light count
    logic [7:0] pat [8] = '{8'h5A, 8'h3C, 8'h1E, 8'h72, 8'h5A, 8'h3C, 8'h1E, 8'h72};
    always #4 mclk = ~mclk;
    irt_tx_ctrl irt_tx_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata_ff(reg_rdata_ff), .cfg(cfg), .pat_valid(pat_valid), .pat_data(pat_data),
        .pat_ready(pat_ready), .pattern_addr_ff(pattern_addr_ff),
        .emitter_on_ff(emitter_on_ff), .transmit_in_progress_ff(transmit_in_progress_ff),
        .transmit_done_flag_ff(transmit_done_flag_ff),
        .main_status_done_ff(main_status_done_ff));
    irt_ir_receiver irt_ir_receiver_inst (.mclk(mclk), .clr(clr),
        .listen(transmit_in_progress_ff), .emitter_on_ff(emitter_on_ff),
        .on_cycles(on_cycles), .max_off(max_off), .frame_cycles(frame_cycles));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // One-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
        @(negedge mclk);
        reg_req.wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        reg_req.rd_en = 1'b0;
        chk(reg_rdata_ff, exp);
    endtask : rd
    task automatic push(input logic [7:0] b);
        @(negedge mclk);
        pat_valid = 1'b1;
        pat_data = b;
        // Ready is looked at between edges, where it has settled
        while (pat_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        pat_valid = 1'b0;
        pat_data = ~b;
    endtask : push
    // Fill the buffer to refusal, send one full frame, then check light and gaps
    task automatic run(input logic [7:0] mode, input logic en);
        cfg.transmit_done_irq_enable = en;
        foreach (pat[i]) push(pat[i]);
        chk(pat_ready, 1'b0);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        wr(irt_pkg::TRANSMIT_LAUNCH_ADDR, mode);
        rd(irt_pkg::TRANSMIT_LAUNCH_ADDR, mode);
        rd(irt_pkg::TRANSMIT_STATUS_ADDR, 8'h01);
        for (int i = 0; i < 20000 && transmit_in_progress_ff; i++) @(negedge mclk);
        chk(transmit_in_progress_ff, 1'b0);
        @(negedge mclk);
        chk(pattern_addr_ff, 2 * (cfg.symbol_repeat_count + 1) * (cfg.packet_repeat_count + 1));
        chk(on_cycles, ones * bit_cyc);
        chk(max_off, (2 * cfg.inter_packet_gap + 3) * bit_cyc);
        chk(frame_cycles, bit_cyc * (2 * irt_pkg::BYTE_BITS * (cfg.symbol_repeat_count + 1)
            * (cfg.packet_repeat_count + 1) + cfg.symbol_repeat_count
            * (cfg.packet_repeat_count + 1) * (2 * cfg.inter_symbol_gap + 1)
            + cfg.packet_repeat_count * (2 * cfg.inter_packet_gap + 1)));
        chk(main_status_done_ff, en);
        rd(irt_pkg::TRANSMIT_STATUS_ADDR, {6'h00, en, 1'b0});
        rd(irt_pkg::TRANSMIT_STATUS_ADDR, 8'h00);
    endtask : run
    task automatic results();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    // Two frames of about 8000 cycles each, with ample margin
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        results();
    end
    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        rd(irt_pkg::SYMBOL_BYTE_COUNT_ADDR, irt_pkg::SYMBOL_BYTE_COUNT_RST);
        rd(irt_pkg::TRANSMIT_STATUS_ADDR, 8'h00);
        rd(irt_pkg::TRANSMIT_LAUNCH_ADDR, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], rows[i][2]);
        end
        // Two-byte symbols, inter-symbol gap setting at its floor, two symbols and two packets
        cfg = '{bit_time_setting: 6'h01, symbol_repeat_count: 8'h01,
            packet_repeat_count: 8'h01, inter_symbol_gap: 8'h08, inter_packet_gap: 8'h0C,
            transmit_done_irq_enable: 1'b0};
        bit_cyc = (cfg.bit_time_setting + 1) * irt_pkg::QUARTER_CYC;
        ones = 0;
        foreach (pat[i]) ones += $countones(pat[i]);
        run(8'h01, 1'b1);
        run(8'h02, 1'b0);
        // Stop with the done enable set: a stop must not raise the done flag
        cfg.transmit_done_irq_enable = 1'b1;
        push(8'hFF);
        push(8'hFF);
        wr(irt_pkg::TRANSMIT_LAUNCH_ADDR, 8'h02);
        repeat (100) @(negedge mclk);
        // Remote bit still written as one, so this write is ignored
        wr(irt_pkg::TRANSMIT_LAUNCH_ADDR, 8'h03);
        rd(irt_pkg::TRANSMIT_LAUNCH_ADDR, 8'h02);
        wr(irt_pkg::TRANSMIT_LAUNCH_ADDR, 8'h00);
        chk(transmit_in_progress_ff, 1'b0);
        @(negedge mclk);
        chk({emitter_on_ff, transmit_done_flag_ff}, 2'b00);
        // Reset in mid-frame, held across three rising edges so no flag edge survives it
        wr(irt_pkg::TRANSMIT_LAUNCH_ADDR, 8'h01);
        repeat (20) @(negedge mclk);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        chk({transmit_in_progress_ff, emitter_on_ff, pat_ready, transmit_done_flag_ff,
            main_status_done_ff, pattern_addr_ff}, 13'h0000);
        rst_n = 1'b1;
        rd(irt_pkg::TRANSMIT_STATUS_ADDR, 8'h00);
        rd(irt_pkg::TRANSMIT_LAUNCH_ADDR, 8'h00);
        results();
    end
endmodule : test_irt_tx_ctrl
